// *** core/baud_prescaler.sv ***
// Baud-rate prescaler: one-cycle tick every 2^(n+1) main clocks
module baud_prescaler
  import tws_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Control
  input wire logic run,
  input wire logic [3:0] sel,
  // Tick
  output logic tick
);

  logic [7:0] cnt_r;
  logic [7:0] last_cnt;
  logic sel_ok;

  // Prohibited codes keep the generator silent instead of picking a rate
  assign sel_ok = (sel <= PRESCALE_MAX_SEL);
  // Shift amount is widened first, otherwise code 7 wraps to a divide by one
  assign last_cnt = 8'((9'h001 << ({1'b0, sel[2:0]} + 4'h1)) - 9'h001);
  assign tick = run && sel_ok && (cnt_r == last_cnt);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 8'h00;
    end else if (!run || tick) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

endmodule : baud_prescaler

// *** core/bit_counter.sv ***
// Serial clock counter: counts steps and flags the last one of a transfer
module bit_counter #(
  parameter int LIMIT = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Control
  input wire logic clear,
  input wire logic step,
  // Result
  output logic last
);

  logic [3:0] cnt_r;

  assign last = step && (cnt_r == 4'(LIMIT - 1));

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 4'h0;
    end else if (clear || last) begin
      cnt_r <= 4'h0;
    end else if (step) begin
      cnt_r <= cnt_r + 4'h1;
    end
  end

endmodule : bit_counter

// *** core/three_wire_serial_port.sv ***
// Three-wire serial port with async frame setup, prescaler and register port
////////////////////////////////////////////////////////////////////////////////
// How it works
// - Parity field picks none, zero, odd, even
// - Char length 7/8 bits, stop 1/2
// - Prescaler nibble divides main clock by 2^(n+1)
// - Internal serial clock is main clock over 2^(n+2)
// - Reset clears prescaler register to zero
// - Eight bits per transfer, one per clock
// - Default phase: output on fall, sample rise
// - After eighth bit stop and raise interrupt
// - Slave select high floats data output
// - Slave data output high after last bit until deselect, only when phase and polarity bits differ
// - Idle data output keeps last bit sent
// - Data write starts only when enabled and idle
// - Enabling after data write starts nothing
// - Phase bit picks falling or rising output edge
// - Polarity bit picks idle high or idle low
// - Source bit picks pin or internal generator
module three_wire_serial_port
  import tws_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  // Serial clock pin
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe_n,
  // Serial data pins
  output logic serial_out_pin_out,
  output logic serial_out_pin_oe_n,
  input wire logic serial_in_pin,
  input wire logic slave_select_pin_n,
  // Transfer event
  output logic transfer_done_irq,
  // Async frame setup
  output logic transmit_enable_bit,
  output logic receive_enable_bit,
  output logic [3:0] async_char_bits,
  output logic [1:0] async_stop_bits,
  output logic async_parity_add,
  output logic async_parity_check,
  output logic async_parity_value
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] async_mode_control_r;
  logic [7:0] sync_mode_control_r;
  logic [7:0] baud_prescaler_control_r;
  logic [7:0] transmit_shift_reg_r;
  logic [7:0] last_tx_r;
  logic [7:0] receive_shift_reg_r;
  logic [7:0] receive_buffer_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  xfer_state_t state_r;
  logic sck_r;
  logic sck_prev_r;
  logic so_r;
  logic so_high_r;
  logic irq_r;

  logic sync_operation_enable;
  logic slave_select_use;
  logic data_phase_bit;
  logic first_bit_order;
  logic clock_source_bit;
  logic clock_polarity_bit;
  logic [3:0] prescale_sel;
  parity_mode_t parity_mode;
  logic [6:0] char_data;

  logic is_slave;
  logic deselected;
  logic preload;
  logic tick;
  logic rise;
  logic fall;
  logic out_edge;
  logic smp_edge;
  logic last_bit;
  logic start;
  logic sck_idle;
  logic next_out;

  assign sync_operation_enable = sync_mode_control_r[ENABLE_BIT];
  assign slave_select_use = sync_mode_control_r[SSUSE_BIT];
  assign data_phase_bit = sync_mode_control_r[DAP_BIT];
  assign first_bit_order = sync_mode_control_r[DIR_BIT];
  assign clock_source_bit = sync_mode_control_r[CCK_BIT];
  assign clock_polarity_bit = sync_mode_control_r[CKP_BIT];
  assign prescale_sel = baud_prescaler_control_r[7:PRESCALE_SEL_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      async_mode_control_r <= ASYNC_MODE_RST;
      sync_mode_control_r <= SYNC_MODE_RST;
      baud_prescaler_control_r <= PRESCALE_RST;
    end else if (wr_en) begin
      if (addr == ASYNC_MODE_OFS) begin
        // Bits 1:0 are held at zero whatever software writes
        async_mode_control_r <= wdata & ASYNC_MODE_MASK;
      end else if (addr == SYNC_MODE_OFS) begin
        sync_mode_control_r <= wdata & SYNC_MODE_MASK;
      end else if (addr == PRESCALE_OFS) begin
        baud_prescaler_control_r <= wdata & PRESCALE_MASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads, data one cycle after the strobe
  always_comb begin
    rdata_nxt = 8'h00;
    if (addr == ASYNC_MODE_OFS) begin
      rdata_nxt = async_mode_control_r;
    end else if (addr == SYNC_MODE_OFS) begin
      rdata_nxt = sync_mode_control_r;
    end else if (addr == PRESCALE_OFS) begin
      rdata_nxt = baud_prescaler_control_r;
    end else if (addr == SHIFT_DATA_OFS) begin
      rdata_nxt = receive_buffer_r;
    end else if (addr == STATUS_OFS) begin
      rdata_nxt[BUSY_BIT] = (state_r != XFER_IDLE);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 8'h00;
    end else if (rd_en) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign rdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Async frame setup
  assign parity_mode = parity_mode_t'(async_mode_control_r[PS_HI_BIT:PS_LO_BIT]);
  // Parity works on the last word that started a transfer, since the shifter empties as it sends
  assign char_data = last_tx_r[6:0];
  assign transmit_enable_bit = async_mode_control_r[TXE_BIT];
  assign receive_enable_bit = async_mode_control_r[RXE_BIT];
  assign async_char_bits = async_mode_control_r[CL_BIT] ? CHAR_BITS_LONG : CHAR_BITS_SHORT;
  assign async_stop_bits = async_mode_control_r[SL_BIT] ? STOP_BITS_TWO : STOP_BITS_ONE;

  always_comb begin
    async_parity_add = 1'b1;
    async_parity_check = 1'b0;
    async_parity_value = 1'b0;
    case (parity_mode)
      PARITY_NONE: begin
        async_parity_add = 1'b0;
      end
      PARITY_ZERO: begin
        async_parity_value = 1'b0;
      end
      PARITY_ODD: begin
        async_parity_check = 1'b1;
        async_parity_value = ~(^{last_tx_r[7] & async_mode_control_r[CL_BIT], char_data});
      end
      default: begin
        async_parity_check = 1'b1;
        async_parity_value = ^{last_tx_r[7] & async_mode_control_r[CL_BIT], char_data};
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock generation and edge detection
  assign is_slave = !clock_source_bit;
  assign deselected = slave_select_use && is_slave && slave_select_pin_n;
  assign sck_idle = !clock_polarity_bit;
  // First bit goes out at start when the leading edge is a sampling edge
  assign preload = (data_phase_bit != clock_polarity_bit);

  baud_prescaler u_prescaler (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .run(sync_operation_enable && clock_source_bit && (state_r != XFER_IDLE)),
    .sel(prescale_sel),
    .tick(tick)
  );

  always_comb begin
    rise = 1'b0;
    fall = 1'b0;
    if (state_r == XFER_RUN) begin
      if (clock_source_bit) begin
        // Each tick toggles the line, so a full period takes two ticks
        rise = tick && !sck_r;
        fall = tick && sck_r;
      end else if (!deselected) begin
        rise = serial_clock_pin_in && !sck_prev_r;
        fall = !serial_clock_pin_in && sck_prev_r;
      end
    end
  end

  assign out_edge = data_phase_bit ? rise : fall;
  assign smp_edge = data_phase_bit ? fall : rise;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_prev_r <= 1'b1;
    end else begin
      sck_prev_r <= serial_clock_pin_in;
    end
  end

  bit_counter #(
    .LIMIT(BITS_PER_XFER)
  ) u_bit_counter (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clear(state_r == XFER_IDLE),
    .step(smp_edge),
    .last(last_bit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Transfer control
  // A write while disabled is dropped, so a later enable finds nothing to send
  assign start = wr_en && (addr == SHIFT_DATA_OFS) && sync_operation_enable
    && (state_r == XFER_IDLE);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= XFER_IDLE;
    end else if (!sync_operation_enable) begin
      state_r <= XFER_IDLE;
    end else begin
      case (state_r)
        XFER_IDLE: begin
          if (start) begin
            state_r <= XFER_RUN;
          end
        end
        XFER_RUN: begin
          if (last_bit) begin
            // Master must still bring its clock back to idle
            // The last edge toggles the line, so it ends idle only if it was not idle before
            if (clock_source_bit && (sck_r == sck_idle)) begin
              state_r <= XFER_FINISH;
            end else begin
              state_r <= XFER_IDLE;
            end
          end
        end
        XFER_FINISH: begin
          if (tick) begin
            state_r <= XFER_IDLE;
          end
        end
        default: begin
          state_r <= XFER_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_r <= 1'b1;
    end else if (state_r == XFER_IDLE) begin
      sck_r <= sck_idle;
    end else if (tick) begin
      sck_r <= !sck_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shift registers
  assign next_out = first_bit_order ? transmit_shift_reg_r[0] : transmit_shift_reg_r[7];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      transmit_shift_reg_r <= DATA_RST;
      last_tx_r <= DATA_RST;
      so_r <= 1'b0;
    end else if (start) begin
      transmit_shift_reg_r <= wdata;
      last_tx_r <= wdata;
      if (preload) begin
        so_r <= first_bit_order ? wdata[0] : wdata[7];
        transmit_shift_reg_r <= first_bit_order ? {1'b0, wdata[7:1]} : {wdata[6:0], 1'b0};
      end
    end else if (out_edge && !last_bit) begin
      so_r <= next_out;
      transmit_shift_reg_r <= first_bit_order ? {1'b0, transmit_shift_reg_r[7:1]}
        : {transmit_shift_reg_r[6:0], 1'b0};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      receive_shift_reg_r <= DATA_RST;
    end else if (smp_edge) begin
      receive_shift_reg_r <= first_bit_order ? {serial_in_pin, receive_shift_reg_r[7:1]}
        : {receive_shift_reg_r[6:0], serial_in_pin};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      receive_buffer_r <= DATA_RST;
    end else if (last_bit) begin
      receive_buffer_r <= first_bit_order ? {serial_in_pin, receive_shift_reg_r[7:1]}
        : {receive_shift_reg_r[6:0], serial_in_pin};
    end
  end

  // Interrupt pulse marks the end of the eighth bit
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= last_bit;
    end
  end

  assign transfer_done_irq = irq_r;

  // Selected slave drives high after its last bit until deselected, only when preload is set
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      so_high_r <= 1'b0;
    end else if (slave_select_pin_n || !slave_select_use || !is_slave) begin
      so_high_r <= 1'b0;
    end else if (last_bit && preload) begin
      so_high_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers
  // so_r is never cleared after a transfer, so the idle line keeps the last bit
  assign serial_out_pin_out = so_high_r | so_r;
  assign serial_out_pin_oe_n = deselected;
  assign serial_clock_pin_out = sck_r;
  assign serial_clock_pin_oe_n = !(sync_operation_enable && clock_source_bit);

endmodule : three_wire_serial_port

// *** core/tws_pkg.sv ***
// Package with register map, field positions and reset values of the three-wire serial port
package tws_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [15:0] ASYNC_MODE_OFS = 16'hff70;
  localparam logic [15:0] SYNC_MODE_OFS = 16'hff72;
  localparam logic [15:0] PRESCALE_OFS = 16'hff73;
  localparam logic [15:0] SHIFT_DATA_OFS = 16'hff74;
  localparam logic [15:0] STATUS_OFS = 16'hff75;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] ASYNC_MODE_RST = 8'h00;
  localparam logic [7:0] SYNC_MODE_RST = 8'h00;
  localparam logic [7:0] PRESCALE_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Async mode fields
  localparam int TXE_BIT = 7;
  localparam int RXE_BIT = 6;
  localparam int PS_HI_BIT = 5;
  localparam int PS_LO_BIT = 4;
  localparam int CL_BIT = 3;
  localparam int SL_BIT = 2;
  localparam logic [7:0] ASYNC_MODE_MASK = 8'h00fc;

  // Sync mode fields
  localparam int ENABLE_BIT = 7;
  localparam int SSUSE_BIT = 6;
  localparam int DAP_BIT = 3;
  localparam int DIR_BIT = 2;
  localparam int CCK_BIT = 1;
  localparam int CKP_BIT = 0;
  localparam logic [7:0] SYNC_MODE_MASK = 8'h00cf;

  // Prescaler fields
  localparam int PRESCALE_SEL_LSB = 4;
  localparam logic [7:0] PRESCALE_MASK = 8'h00f0;
  localparam logic [3:0] PRESCALE_MAX_SEL = 4'h7;

  // Status fields
  localparam int BUSY_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Frame constants
  localparam int BITS_PER_XFER = 8;
  localparam logic [3:0] CHAR_BITS_SHORT = 4'h7;
  localparam logic [3:0] CHAR_BITS_LONG = 4'h8;
  localparam logic [1:0] STOP_BITS_ONE = 2'h1;
  localparam logic [1:0] STOP_BITS_TWO = 2'h2;

  typedef enum logic [1:0] {
    PARITY_NONE = 2'b00,
    PARITY_ZERO = 2'b01,
    PARITY_ODD = 2'b10,
    PARITY_EVEN = 2'b11
  } parity_mode_t;

  typedef enum logic [1:0] {
    XFER_IDLE = 2'b00,
    XFER_RUN = 2'b01,
    XFER_FINISH = 2'b10
  } xfer_state_t;

endpackage : tws_pkg

// *** sim/serial_peer.sv ***
// Far-end model: idle-high clock, first bit ready at load, shifts on fall, samples on rise
module serial_peer (
  // Clock
  input wire logic ref_clk,
  // Wires
  input wire logic sck,
  input wire logic sdo,
  output logic sdi,
  // Test side
  input wire logic load,
  input wire logic [7:0] tx_byte,
  output logic [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh_r;
  logic [3:0] left_r;
  logic sck_d_r;
  initial begin
    sdi = 1'b0;
    sck_d_r = 1'b1;
    left_r = 4'h0;
    rx_byte = 8'h00;
  end
  always @(posedge ref_clk) begin
    sck_d_r <= sck;
    if (load) begin
      sdi <= tx_byte[7];
      sh_r <= {tx_byte[6:0], 1'b0};
      left_r <= 4'h8;
    end else if (left_r == 4'h0) begin
      sdi <= ~sdi; // Outside a frame the line carries no stale bit
    end else if (!sck && sck_d_r && left_r != 4'h8) begin
      sdi <= sh_r[7];
      sh_r <= {sh_r[6:0], 1'b0};
    end else if (sck && !sck_d_r) begin
      rx_byte <= {rx_byte[6:0], sdo};
      left_r <= left_r - 4'h1;
    end
  end
endmodule : serial_peer

// *** sim/tb.sv ***
// Self-checking bench for the three-wire serial port
module tb;
  import tws_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst_n, wr_en, rd_en, rd_d_r, sck_ext, ss_n, pload;
  logic sck_out, sck_oe_n, so_out, so_oe_n, sdi, irq, txe, rxe, padd, pchk, pval;
  logic [15:0] addr;
  logic [7:0] wdata, rdata, ptx, prx, tx, pt, v;
  logic [3:0] cbits;
  logic [1:0] sbits;
  logic [7:0] exp_q[$];
  int fails, checks_done, n, h;
  wire sck_w = sck_oe_n ? sck_ext : sck_out;
  three_wire_serial_port dut (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .serial_clock_pin_in(sck_w),
    .serial_clock_pin_out(sck_out), .serial_clock_pin_oe_n(sck_oe_n), .serial_out_pin_out(so_out),
    .serial_out_pin_oe_n(so_oe_n), .serial_in_pin(sdi), .slave_select_pin_n(ss_n),
    .transfer_done_irq(irq), .transmit_enable_bit(txe), .receive_enable_bit(rxe),
    .async_char_bits(cbits), .async_stop_bits(sbits), .async_parity_add(padd),
    .async_parity_check(pchk), .async_parity_value(pval));
  serial_peer peer (.ref_clk(ref_clk), .sck(sck_w), .sdo(so_out), .sdi(sdi), .load(pload),
    .tx_byte(ptx), .rx_byte(prx));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Strobes stay as set until the next call, so back-to-back cycles never re-drive in one step
  task automatic bus(input logic w, input logic r, input logic [15:0] a, input logic [7:0] d);
    wr_en <= w;
    rd_en <= r;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
  endtask : bus
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask : rd
  task automatic idle(input int c);
    repeat (c) bus(1'b0, 1'b0, 16'h0000, 8'h00);
  endtask : idle
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop
  // Read data stand only in the cycle after the strobe
  always @(posedge ref_clk) begin
    rd_d_r <= rd_en;
    if (rd_d_r) check(rdata, exp_q.pop_front(), "rdata");
  end
  // Longest run is about 8400 cycles of slow transfers
  initial begin
    repeat (30000) @(posedge ref_clk);
    fails++;
    report_and_stop();
  end
  ////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    {wr_en, rd_en, rd_d_r, pload} = 4'h0;
    {sck_ext, ss_n} = 2'b11;
    addr = 16'h0000;
    wdata = 8'h00;
    ptx = 8'h00;
    void'($urandom(48963));
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    idle(1);
    rd(PRESCALE_OFS, PRESCALE_RST);
    rd(SYNC_MODE_OFS, SYNC_MODE_RST);
    rd(ASYNC_MODE_OFS, ASYNC_MODE_RST);
    rd(16'hff71, 8'h00);
    wr(PRESCALE_OFS, 8'hff);
    rd(PRESCALE_OFS, PRESCALE_MASK);
    wr(SYNC_MODE_OFS, 8'h00);
    wr(SHIFT_DATA_OFS, 8'ha5);
    wr(SYNC_MODE_OFS, 8'h82);
    idle(20);
    rd(STATUS_OFS, 8'h00);
    for (int s = 0; s < 8; s++) begin
      tx = 8'($urandom);
      pt = 8'($urandom);
      h = 2 << s;
      wr(PRESCALE_OFS, {s[3:0], 4'h0});
      ptx <= pt;
      pload <= 1'b1;
      wr(SHIFT_DATA_OFS, tx);
      pload <= 1'b0;
      wr(SHIFT_DATA_OFS, ~tx);
      n = 0;
      while (irq !== 1'b1 && n < 5000) begin
        idle(1);
        n++;
      end
      check({7'h0, n >= 15 * h - 4 && n <= 16 * h + 4}, 8'h01, "transfer length");
      idle(1);
      rd(SHIFT_DATA_OFS, pt);
      rd(STATUS_OFS, 8'h00);
      check(prx, tx, "peer byte");
      check({7'h0, so_out}, {7'h0, tx[0]}, "held out bit");
    end
    wr(SYNC_MODE_OFS, 8'h00);
    for (int m = 0; m < 16; m++) begin
      wr(ASYNC_MODE_OFS, {2'b11, m[3:0], 2'b00});
      idle(1);
      v = m[1] ? tx : {1'b0, tx[6:0]};
      check({4'h0, cbits}, m[1] ? 8'h08 : 8'h07, "char bits");
      check({6'h0, sbits}, m[0] ? 8'h02 : 8'h01, "stop bits");
      check({6'h0, padd, pchk}, {6'h0, m[3:2] != 2'b00, m[3]}, "parity mode");
      if (m[3:2] != 2'b00) check({7'h0, pval}, {7'h0, m[3] && (m[2] ^ ~^v)}, "parity bit");
      check({6'h0, txe, rxe}, 8'h03, "enables");
    end
    wr(ASYNC_MODE_OFS, 8'h03);
    rd(ASYNC_MODE_OFS, 8'h00);
    wr(SYNC_MODE_OFS, 8'hc0);
    idle(2);
    check({6'h0, so_oe_n, sck_oe_n}, 8'h03, "deselected out");
    ss_n <= 1'b0;
    idle(2);
    check({6'h0, so_oe_n, sck_oe_n}, 8'h01, "selected out");
    wr(SYNC_MODE_OFS, 8'h82);
    wr(PRESCALE_OFS, 8'h80);
    wr(SHIFT_DATA_OFS, 8'h3c);
    idle(40);
    rd(STATUS_OFS, 8'h01);
    wr(SYNC_MODE_OFS, 8'h00);
    idle(1);
    rd(STATUS_OFS, 8'h00);
    // Slave transfer on an external clock while the select pin is low
    tx = 8'($urandom);
    pt = 8'($urandom);
    wr(SYNC_MODE_OFS, 8'hc0);
    ptx <= pt;
    pload <= 1'b1;
    wr(SHIFT_DATA_OFS, tx);
    pload <= 1'b0;
    idle(3);
    rd(STATUS_OFS, 8'h01);
    repeat (8) begin
      sck_ext <= 1'b0;
      idle(4);
      sck_ext <= 1'b1;
      idle(4);
    end
    idle(2);
    rd(SHIFT_DATA_OFS, pt);
    rd(STATUS_OFS, 8'h00);
    check(prx, tx, "slave peer byte");
    check({7'h0, so_out}, {7'h0, tx[0]}, "slave held bit");
    ss_n <= 1'b1;
    idle(2);
    check({7'h0, so_oe_n}, 8'h01, "slave released out");
    idle(2);
    report_and_stop();
  end
endmodule : tb

// *** sim/tws_checker.sv ***
// Concurrent checks on the serial port's registers and pins
module tws_checker
  import tws_pkg::*;
(
  // Clock and reset
  input logic ref_clk,
  input logic rst_n,
  // Register port
  input logic [15:0] addr,
  input logic [7:0] wdata,
  input logic wr_en,
  input logic rd_en,
  input logic [7:0] rdata,
  // Pins
  input logic serial_clock_pin_out,
  input logic serial_clock_pin_oe_n,
  input logic serial_out_pin_out,
  input logic serial_out_pin_oe_n,
  input logic slave_select_pin_n,
  input logic transfer_done_irq,
  // Async frame setup
  input logic [3:0] async_char_bits,
  input logic [1:0] async_stop_bits,
  input logic async_parity_add,
  input logic async_parity_check
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  // Shadow registers rebuilt from bus writes, so checks need no internal probes
  logic [7:0] async_r, sync_r;
  logic pre_wr_r, busy_r, sck_d_r, start;
  logic [3:0] rise_r, rises;
  assign start = wr_en && addr == SHIFT_DATA_OFS && sync_r[ENABLE_BIT] && !busy_r;
  assign rises = rise_r + {3'h0, serial_clock_pin_out && !sck_d_r};
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      async_r <= 8'h00;
      sync_r <= 8'h00;
      pre_wr_r <= 1'b0;
    end else if (wr_en) begin
      if (addr == ASYNC_MODE_OFS) async_r <= wdata & ASYNC_MODE_MASK;
      if (addr == SYNC_MODE_OFS) sync_r <= wdata & SYNC_MODE_MASK;
      if (addr == PRESCALE_OFS) pre_wr_r <= 1'b1;
    end
  end
  // Clock rises seen since the last accepted start
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      rise_r <= 4'h0;
      sck_d_r <= 1'b1;
    end else begin
      sck_d_r <= serial_clock_pin_out;
      if (start) begin
        busy_r <= 1'b1;
        rise_r <= 4'h0;
      end else begin
        if (transfer_done_irq || (wr_en && addr == SYNC_MODE_OFS && !wdata[ENABLE_BIT])) busy_r <= 1'b0;
        rise_r <= rises;
      end
    end
  end
  ////////////////////////////////////////
  a_irq_one_pulse: assert property (transfer_done_irq |=> !transfer_done_irq)
    else $error("done pulse wider than one cycle");
  a_eight_rises: assert property (transfer_done_irq && !serial_clock_pin_oe_n |-> rises == 4'h8)
    else $error("done without eight clock rises");
  a_sck_idle_level: assert property (transfer_done_irq && !serial_clock_pin_oe_n &&
    sync_r[DAP_BIT] == sync_r[CKP_BIT] |-> (serial_clock_pin_out == !sync_r[CKP_BIT]) [*3])
    else $error("serial clock not idle after transfer");
  a_sck_drive: assert property (serial_clock_pin_oe_n == !(sync_r[ENABLE_BIT] && sync_r[CCK_BIT]))
    else $error("clock drive does not follow source bit");
  a_ss_floats_out: assert property (sync_r[ENABLE_BIT] && sync_r[SSUSE_BIT] && !sync_r[CCK_BIT] &&
    slave_select_pin_n |-> serial_out_pin_oe_n)
    else $error("data out driven while deselected");
  a_so_on_edge: assert property ($changed(serial_out_pin_out) && !serial_clock_pin_oe_n &&
    !$past(wr_en) |-> $changed(serial_clock_pin_out))
    else $error("data out moved without a clock edge");
  a_async_lengths: assert property (async_char_bits == (async_r[CL_BIT] ? CHAR_BITS_LONG : CHAR_BITS_SHORT) &&
    async_stop_bits == (async_r[SL_BIT] ? STOP_BITS_TWO : STOP_BITS_ONE))
    else $error("frame lengths wrong");
  a_parity_flags: assert property (async_parity_add == (async_r[PS_HI_BIT:PS_LO_BIT] != 2'b00) &&
    async_parity_check == async_r[PS_HI_BIT])
    else $error("parity mode decode wrong");
  a_no_late_start: assert property (wr_en && addr == SHIFT_DATA_OFS && !sync_r[ENABLE_BIT]
    |=> !transfer_done_irq [*8])
    else $error("transfer from data written while disabled");
  a_prescale_reset: assert property (rd_en && addr == PRESCALE_OFS && !pre_wr_r |=> rdata == PRESCALE_RST)
    else $error("prescaler not clear after reset");
endmodule : tws_checker

bind three_wire_serial_port tws_checker chk (.ref_clk, .rst_n, .addr, .wdata, .wr_en, .rd_en, .rdata,
  .serial_clock_pin_out, .serial_clock_pin_oe_n, .serial_out_pin_out, .serial_out_pin_oe_n,
  .slave_select_pin_n, .transfer_done_irq, .async_char_bits, .async_stop_bits, .async_parity_add,
  .async_parity_check);
